// File: core/led_port_pkg.sv
package led_port_pkg;

  // Clock and strobe timing
  localparam int CLK_MHZ      = 50;
  localparam int SETUP_NS     = 250;
  localparam int PULSE_NS     = 200;
  localparam int SETUP_CYCLES = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;

  // Display geometry
  localparam int DIGITS     = 8;
  localparam int WORD_W     = 8;
  localparam int NIBBLE_W   = 4;
  localparam int DIGIT_AW   = 3;

  // Control word field positions
  localparam int ADDR_LSB         = 0;
  localparam int BANK_SELECT_BIT  = 3;
  localparam int POWER_ENABLE_BIT = 4;
  localparam int RAW_FORMAT_BIT   = 5;
  localparam int FONT_SELECT_BIT  = 6;
  localparam int MORE_DATA_FLAG   = 7;

  // Control register value after reset
  localparam logic [7:0] CTRL_RESET = 8'h10;

  // Host register map
  localparam logic [7:0] CMD_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam int         CMD_SELECT_BIT = 8;
  localparam int         STAT_BUSY_BIT  = 0;

  typedef logic [WORD_W-1:0] byte_t;

endpackage : led_port_pkg

// File: core/led_port_if.sv
interface led_port_if;
  import led_port_pkg::*;

  logic  write_strobe_n; // Low during a write pulse, data taken on rise
  logic  reg_select;     // High: control word, low: display memory
  byte_t data_in;        // Write data, bits 0 to 7

  modport host (
    output write_strobe_n,
    output reg_select,
    output data_in
  );

  modport device (
    input  write_strobe_n,
    input  reg_select,
    input  data_in
  );

endinterface : led_port_if

// File: core/digit_store.sv
module digit_store
  import led_port_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wr_en_i,
  input  wire logic [DIGIT_AW-1:0]        wr_addr_i,
  input  wire logic                       wr_raw_i,
  input  wire logic                       wr_bank_a_i,
  input  wire byte_t                      wr_data_i,
  input  wire logic                       show_raw_i,
  input  wire logic                       show_bank_a_i,
  output logic      [DIGITS*WORD_W-1:0]   words_o
);

  logic [NIBBLE_W-1:0] nib_a_reg [DIGITS];
  logic [NIBBLE_W-1:0] nib_b_reg [DIGITS];
  logic                dp_reg    [DIGITS];

  ////////////////////////////////////////////////////////////////////////////
  // Memory write: raw words span both banks, decoded words one bank
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DIGITS; i++) begin
        nib_a_reg[i] <= '0;
        nib_b_reg[i] <= '0;
        dp_reg[i]    <= 1'b0;
      end
    end else if (wr_en_i) begin
      dp_reg[wr_addr_i] <= wr_data_i[WORD_W-1]; // R08
      if (wr_raw_i) begin // R07
        nib_a_reg[wr_addr_i] <= wr_data_i[NIBBLE_W-1:0];
        nib_b_reg[wr_addr_i] <= wr_data_i[WORD_W-1:NIBBLE_W];
      end else if (wr_bank_a_i) begin // R09
        nib_a_reg[wr_addr_i] <= wr_data_i[NIBBLE_W-1:0];
      end else begin
        nib_b_reg[wr_addr_i] <= wr_data_i[NIBBLE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read out every digit in the current format and bank
  always_comb begin
    for (int i = 0; i < DIGITS; i++) begin
      if (show_raw_i) begin
        words_o[i*WORD_W +: WORD_W] = {dp_reg[i], nib_b_reg[i][2:0],
                                       nib_a_reg[i]};
      end else if (show_bank_a_i) begin // R06
        words_o[i*WORD_W +: WORD_W] = {dp_reg[i], 3'h0, nib_a_reg[i]};
      end else begin
        words_o[i*WORD_W +: WORD_W] = {dp_reg[i], 3'h0, nib_b_reg[i]};
      end
    end
  end

endmodule : digit_store

// File: core/led_display_device.sv
// Functional notes
// (R01) Strobe selects device and times write
// (R02) Two locations chosen by register select
// (R03) Host drives eight data bits per strobe
// (R04) Every mode starts with control write
// (R05) Control bits: power, format, font, bank, address
// (R06) Two memory banks in decoded formats
// (R07) Raw words eight bits, decoded four bits
// (R08) Decimal point independent of bank
// (R09) Captured bank bit picks written bank
// (R10) Control write without flag updates control only
// (R11) Flag high blanks and starts sequential load
// (R12) Eight writes fill digits one to eight
// (R13) Unblank after eighth digit stored
// (R14) Ignore data writes after load completes
// (R15) Loaded digits shown in preceding format
// (R16) Flag-high control write restarts digit pointer
// (R17) Power bit high runs, low shuts down
// (R18) Raw bit high raw, font high hex
// (R19) Bank bit high A, low B, decoded
// (R20) Single digit update writes addressed digit
//
// The implementer's own choices: the Wishbone slave port and the address map.
module led_display_device
  import led_port_pkg::*;
#(
  parameter int NUM_DIGITS = DIGITS
)(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  led_port_if.device                       port,
  output logic                             power_on_o,
  output logic                             blank_o,
  output logic                             raw_format_o,
  output logic                             hex_font_o,
  output logic                             bank_a_o,
  output logic                             load_busy_o,
  output logic [DIGIT_AW-1:0]              load_pointer_o,
  output logic [NUM_DIGITS*WORD_W-1:0]     digit_words_o
);

  // Elaboration check: memory and pointer are sized for eight digits
  if (NUM_DIGITS != DIGITS) begin : g_bad_digits
    $error("led_display_device serves exactly eight digits");
  end

  typedef enum logic [1:0] {
    IDLE,
    SEQ_LOAD,
    SINGLE_WAIT
  } entry_e;

  // Field extraction from a control word
  function automatic logic field(input byte_t word, input int pos);
    field = word[pos];
  endfunction : field

  entry_e                 state_reg;
  entry_e                 state_next;
  byte_t                  ctrl_reg;
  logic                   strobe_prev_reg;
  logic [DIGIT_AW-1:0]    ptr_reg;
  logic [DIGIT_AW-1:0]    single_addr_reg;
  logic                   seq_blank_reg;
  logic                   write_event;
  logic                   ctrl_write;
  logic                   data_write;
  logic                   mem_we;
  logic [DIGIT_AW-1:0]    mem_addr;
  logic [NUM_DIGITS*WORD_W-1:0] store_words;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edge detection: a write lands on the rising edge of the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= port.write_strobe_n;
    end
  end

  // Data and select are stable across the rising edge of the strobe
  assign write_event = !strobe_prev_reg && port.write_strobe_n; // R01
  assign ctrl_write  = write_event && port.reg_select; // R02 R04
  assign data_write  = write_event && !port.reg_select; // R02 R03

  ////////////////////////////////////////////////////////////////////////////
  // Control register: every control write replaces all its bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= port.data_in; // R04 R05 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (data_write) begin
          state_next = IDLE; // R14
        end
      end
      SEQ_LOAD: begin
        if (data_write && ptr_reg == DIGIT_AW'(NUM_DIGITS - 1)) begin
          state_next = IDLE; // R13 R14
        end
      end
      SINGLE_WAIT: begin
        if (data_write) begin
          state_next = IDLE; // R20
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
    // A control write overrides whatever entry was under way
    if (ctrl_write) begin
      if (field(port.data_in, MORE_DATA_FLAG)) begin
        state_next = SEQ_LOAD; // R11
      end else begin
        state_next = SINGLE_WAIT; // R10 R20
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequential digit pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= '0;
    end else if (ctrl_write && field(port.data_in, MORE_DATA_FLAG)) begin
      ptr_reg <= '0; // R16
    end else if (data_write && state_reg == SEQ_LOAD) begin
      ptr_reg <= ptr_reg + DIGIT_AW'(1); // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digit address for a single update, caught with the control word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      single_addr_reg <= '0;
    end else if (ctrl_write) begin
      single_addr_reg <= port.data_in[ADDR_LSB +: DIGIT_AW]; // R20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blanking during a sequential load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_blank_reg <= 1'b0;
    end else if (ctrl_write) begin
      seq_blank_reg <= field(port.data_in, MORE_DATA_FLAG); // R11
    end else if (data_write && state_reg == SEQ_LOAD
                 && ptr_reg == DIGIT_AW'(NUM_DIGITS - 1)) begin
      seq_blank_reg <= 1'b0; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory write port: only inside a load or a pending single update
  always_comb begin
    mem_we   = 1'b0;
    mem_addr = ptr_reg;
    if (data_write && state_reg == SEQ_LOAD) begin
      mem_we   = 1'b1; // R12
      mem_addr = ptr_reg;
    end else if (data_write && state_reg == SINGLE_WAIT) begin
      mem_we   = 1'b1; // R20
      mem_addr = single_addr_reg;
    end
  end

  digit_store u_store (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wr_en_i       (mem_we),
    .wr_addr_i     (mem_addr),
    .wr_raw_i      (field(ctrl_reg, RAW_FORMAT_BIT)), // R07 R15
    .wr_bank_a_i   (field(ctrl_reg, BANK_SELECT_BIT)), // R09 R19
    .wr_data_i     (port.data_in),
    .show_raw_i    (field(ctrl_reg, RAW_FORMAT_BIT)), // R15 R18
    .show_bank_a_i (field(ctrl_reg, BANK_SELECT_BIT)), // R06 R10
    .words_o       (store_words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered display state toward the scan and decode logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_on_o     <= 1'b0;
      blank_o        <= 1'b1;
      raw_format_o   <= 1'b0;
      hex_font_o     <= 1'b0;
      bank_a_o       <= 1'b0;
      load_busy_o    <= 1'b0;
      load_pointer_o <= '0;
      digit_words_o  <= '0;
    end else begin
      power_on_o     <= field(ctrl_reg, POWER_ENABLE_BIT); // R17
      blank_o        <= seq_blank_reg
                        || !field(ctrl_reg, POWER_ENABLE_BIT); // R11 R17
      raw_format_o   <= field(ctrl_reg, RAW_FORMAT_BIT); // R18
      hex_font_o     <= field(ctrl_reg, FONT_SELECT_BIT); // R18
      bank_a_o       <= field(ctrl_reg, BANK_SELECT_BIT)
                        && !field(ctrl_reg, RAW_FORMAT_BIT); // R19
      load_busy_o    <= (state_reg == SEQ_LOAD);
      load_pointer_o <= ptr_reg;
      digit_words_o  <= store_words;
    end
  end

endmodule : led_display_device

// File: core/led_display_host.sv
module led_display_host
  import led_port_pkg::*;
#(
  parameter int SETUP_CYC = SETUP_CYCLES,
  parameter int PULSE_CYC = PULSE_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  led_port_if.host         port
);

  // Elaboration check: both phases need at least one cycle
  if (SETUP_CYC < 1 || PULSE_CYC < 1 || SETUP_CYC > 255
      || PULSE_CYC > 255) begin : g_bad_timing
    $error("led_display_host timing counts must lie in 1..255");
  end

  typedef enum logic [1:0] {
    IDLE,
    SETUP,
    PULSE,
    HOLD
  } phase_e;

  phase_e      phase_reg;
  logic [7:0]  count_reg;
  logic [8:0]  cmd_reg;
  logic        bus_req;
  logic        cmd_take;

  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd_take = bus_req && wb_we_i && wb_adr_i == CMD_OFFSET
                    && wb_sel_i[1:0] == 2'b11 && phase_reg == IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: ack one cycle after the request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i && wb_adr_i == CMD_OFFSET) begin
        wb_dat_o <= {23'h0, cmd_reg};
      end else if (bus_req && !wb_we_i && wb_adr_i == STATUS_OFFSET) begin
        wb_dat_o <= {31'h0, phase_reg != IDLE};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command holding register, written only while the port is idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= '0;
    end else if (cmd_take) begin
      cmd_reg <= wb_dat_i[CMD_SELECT_BIT:0]; // R02 R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle: setup with strobe high, pulse low through the hold phase, release on return to idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= IDLE;
      count_reg <= '0;
    end else begin
      case (phase_reg)
        IDLE: begin
          if (cmd_take) begin
            phase_reg <= SETUP;
            count_reg <= 8'(SETUP_CYC - 1);
          end
        end
        SETUP: begin
          if (count_reg == 8'h00) begin
            phase_reg <= PULSE;
            count_reg <= 8'(PULSE_CYC - 1);
          end else begin
            count_reg <= count_reg - 8'h01;
          end
        end
        PULSE: begin
          if (count_reg == 8'h00) begin
            phase_reg <= HOLD;
          end else begin
            count_reg <= count_reg - 8'h01;
          end
        end
        default: begin
          phase_reg <= IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link pins, all straight from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port.write_strobe_n <= 1'b1;
      port.reg_select     <= 1'b0;
      port.data_in        <= '0;
    end else begin
      if (cmd_take) begin
        port.reg_select <= wb_dat_i[CMD_SELECT_BIT]; // R02
        port.data_in    <= wb_dat_i[WORD_W-1:0]; // R03
      end
      port.write_strobe_n <= !(phase_reg == PULSE
                               || (phase_reg == SETUP
                                   && count_reg == 8'h00)); // R01
    end
  end

endmodule : led_display_host

// File: verif/led_port_checker.sv
module led_port_checker
  import led_port_pkg::*;
#(
  parameter int SETUP_CYC = SETUP_CYCLES,
  parameter int PULSE_CYC = PULSE_CYCLES
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       write_strobe_n,
  input  wire logic       reg_select,
  input  wire byte_t      data_in,
  input  wire logic       load_busy_o,
  input  wire logic       blank_o,
  input  wire logic [2:0] load_pointer_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  int low_cnt;
  int settle_cnt;

  // Count the cycles the strobe has sat low
  always_ff @(posedge clk_i) begin
    if (rst_i || write_strobe_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Cycles since select or data last moved, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || $changed(data_in) || $changed(reg_select)) begin
      settle_cnt <= 0;
    end else if (settle_cnt < 1000) begin
      settle_cnt <= settle_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence seq_ctrl_flag;
    $rose(write_strobe_n) && reg_select && data_in[MORE_DATA_FLAG];
  endsequence
  sequence seq_last_data;
    $rose(write_strobe_n) && !reg_select && load_busy_o &&
      load_pointer_o == 3'h7;
  endsequence
  sequence seq_load_done;
    !load_busy_o && !blank_o;
  endsequence

  chk_data_held: assert property (!write_strobe_n |-> $stable(data_in))
    else $error("data changed while strobe low");
  chk_select_held: assert property (
    !write_strobe_n |-> $stable(reg_select))
    else $error("select changed while strobe low");
  chk_pulse_width: assert property (
    $rose(write_strobe_n) |-> low_cnt == PULSE_CYC + 1)
    else $error("strobe pulse width wrong");
  chk_setup_gap: assert property (
    $fell(write_strobe_n) |-> settle_cnt >= SETUP_CYC - 1)
    else $error("strobe fell too soon");
  chk_busy_cause: assert property (
    $rose(load_busy_o) |-> reg_select && data_in[MORE_DATA_FLAG])
    else $error("load began without control write");
  chk_load_blank: assert property (
    $rose(load_busy_o) |-> ##[0:2] blank_o)
    else $error("display not blanked during load");
  chk_pointer_restart: assert property (
    seq_ctrl_flag |-> ##[1:3] (load_busy_o && load_pointer_o == 3'h0))
    else $error("pointer not back at first digit");
  chk_load_finish: assert property (
    seq_last_data |-> ##[1:4] seq_load_done)
    else $error("load did not end after eighth digit");
endmodule : led_port_checker

// File: verif/tb_top.sv
module tb_top
  import led_port_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic        wb_ack, power_on, blank, raw_fmt, hex_font, bank_a, busy;
  logic [2:0]  ptr;
  logic [63:0] words;
  logic [3:0]  na[8], nb[8];
  logic        dp[8], raw_m, banka_m;
  int          err_count = 0;
  int          checks_done = 0;

  led_port_if port_if();
  led_display_host #(.SETUP_CYC(2), .PULSE_CYC(2)) i_led_display_host (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .port(port_if));
  led_display_device i_led_display_device (
    .clk_i(clk_i), .rst_i(rst_i), .port(port_if), .power_on_o(power_on),
    .blank_o(blank), .raw_format_o(raw_fmt), .hex_font_o(hex_font),
    .bank_a_o(bank_a), .load_busy_o(busy), .load_pointer_o(ptr),
    .digit_words_o(words));
  led_port_checker #(.SETUP_CYC(2), .PULSE_CYC(2)) i_led_port_checker (
    .clk_i(clk_i), .rst_i(rst_i), .write_strobe_n(port_if.write_strobe_n),
    .reg_select(port_if.reg_select), .data_in(port_if.data_in),
    .load_busy_o(busy), .blank_o(blank), .load_pointer_o(ptr));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : check

  task wrap_up();
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // One classic bus cycle, held until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [3:0] sel, input logic [31:0] dat,
                          output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= dat;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_cycle

  // Send one link write and wait for the host to go idle
  task automatic send(input logic sel_bit, input byte_t d);
    logic [31:0] rd;
    wb_cycle(1'b1, 8'h00, 4'hf, {23'h0, sel_bit, d}, rd);
    do wb_cycle(1'b0, 8'h04, 4'hf, 32'h0, rd); while (rd[0] !== 1'b0);
    repeat (3) @(posedge clk_i);
    if (sel_bit) begin
      raw_m   = d[RAW_FORMAT_BIT];
      banka_m = d[BANK_SELECT_BIT];
    end
  endtask : send

  // Data write that the device should take into digit idx
  task automatic put(input int idx, input byte_t d);
    send(1'b0, d);
    dp[idx] = d[7];
    if (raw_m) begin
      na[idx] = d[3:0];
      nb[idx] = {1'b0, d[6:4]};
    end else if (banka_m) na[idx] = d[3:0];
    else nb[idx] = d[3:0];
  endtask : put

  function automatic logic [63:0] exp_words();
    logic [63:0] v;
    for (int i = 0; i < 8; i++) begin
      if (raw_m) v[8*i +: 8] = {dp[i], nb[i][2:0], na[i]};
      else v[8*i +: 8] = {dp[i], 3'b0, banka_m ? na[i] : nb[i]};
    end
    return v;
  endfunction : exp_words

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] rd;
    check({power_on, blank, raw_fmt, hex_font, bank_a}, 64'h10);
    check(words, 64'h0);
    wb_cycle(1'b1, 8'h08, 4'hf, 32'h55, rd);
    wb_cycle(1'b0, 8'h08, 4'hf, 32'h0, rd);
    check(rd, 64'h0);
    wb_cycle(1'b1, 8'h00, 4'h1, 32'h198, rd);
    wb_cycle(1'b0, 8'h04, 4'hf, 32'h0, rd);
    check({rd[0], busy}, 64'h0);
    wb_cycle(1'b0, 8'h00, 4'hf, 32'h0, rd);
    check(rd, 64'h0);
  endtask : t_reset

  task automatic t_seq();
    logic [31:0] rd;
    send(1'b1, 8'h98);
    check({busy, blank, ptr}, 64'h18);
    wb_cycle(1'b0, 8'h00, 4'hf, 32'h0, rd);
    check(rd, 64'h198);
    for (int i = 0; i < 8; i++) put(i, {i == 0, 3'b0, 4'(i + 1)});
    check({busy, blank}, 64'h0);
    check(words, exp_words());
    send(1'b0, 8'h0f);
    check(words, exp_words());
  endtask : t_seq

  task automatic t_bank();
    send(1'b1, 8'h50);
    check({hex_font, bank_a}, 64'h2);
    check(words, exp_words());
    send(1'b1, 8'h18);
    check({bank_a, busy}, 64'h2);
    check(words, exp_words());
  endtask : t_bank

  task automatic t_single();
    send(1'b1, 8'h1d);
    put(5, 8'h07);
    check(words, exp_words());
    send(1'b0, 8'h09);
    check(words, exp_words());
  endtask : t_single

  task automatic t_abort();
    send(1'b1, 8'h98);
    for (int i = 0; i < 3; i++) put(i, 8'h0c);
    send(1'b1, 8'h98);
    check({busy, ptr}, 64'h8);
    for (int i = 0; i < 8; i++) put(i, byte_t'(8'h83 + i));
    check(words, exp_words());
  endtask : t_abort

  task automatic t_power();
    send(1'b1, 8'h08);
    check({power_on, blank}, 64'h1);
    send(1'b1, 8'h18);
    check({power_on, blank}, 64'h2);
  endtask : t_power

  task automatic t_raw();
    send(1'b1, 8'hb8);
    check({raw_fmt, bank_a}, 64'h2);
    for (int i = 0; i < 8; i++) put(i, byte_t'(8'hf5 - 8'h23 * i));
    check(words, exp_words());
  endtask : t_raw

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      na[i] = 4'h0;
      nb[i] = 4'h0;
      dp[i] = 1'b0;
    end
    raw_m   = 1'b0;
    banka_m = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_seq();
    t_bank();
    t_single();
    t_abort();
    t_power();
    t_raw();
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial begin
    #200us;
    err_count++;
    wrap_up();
  end
endmodule : tb_top
